// >>> hw/dpee_defines.svh
// Constants for the dual-port serial EEPROM slave front end
// Overview of operation
// - Both ports read at once in two-host mode
// - Write goes to port first showing first-byte LSB
// - Winner holds; other port refused until write done (a port losing a same-cycle tie is still acked; its write is dropped)
// - Start is data fall with clock high
// - Stop is data rise with clock high
// - Write data committed only at stop
// - Address byte 1010 000 plus read/write bit
// - Page write bumps only three low bits
// - Over eight bytes wrap and overwrite page
// - Current read after read returns n+1
// - Current read after write returns n
// - Nack then stop ends after one byte
// - Acked reads continue through 128-word bank
// - Nack stops data, wait stop, then standby
// - Two-host: port A low bank, B high bank
// - Monitor follows A or B by bank select in two-host mode, A in one-host
// - One-host: port A only, bank select picks bank
// - No acknowledge during internal write cycle (a port that lost a same-cycle tie keeps acknowledging its data bytes)
// - Write-protect low blocks all writes
// - Monitor outputs float when monitor enable low
// - Sample on clock rise, change after fall
`ifndef DPEE_DEFINES_SVH
`define DPEE_DEFINES_SVH
`define DPEE_DEV_TYPE 4'hA
`define DPEE_DEV_SEL 3'h0
`define DPEE_WRITE_US 5000
`define DPEE_CLK_MHZ 250
`define DPEE_WRITE_CYCLES (`DPEE_WRITE_US * `DPEE_CLK_MHZ)
`define DPEE_ERASED 8'hFF
`endif

// >>> hw/dpee_mem.sv
// Two-bank byte memory with two registered read ports and a one-byte write port
`timescale 1ns/1ps
`include "dpee_defines.svh"
module dpee_mem import dpee_pkg::*; #(
   parameter int AW = 8
) (
   input wire logic core_clk, // Core clock
   input wire logic [AW-1:0] rd_a_addr, // Read address, port A
   output logic [7:0] rd_a_data, // Registered read data, port A
   input wire logic [AW-1:0] rd_b_addr, // Read address, port B
   output logic [7:0] rd_b_data, // Registered read data, port B
   input wire logic wr_en, // Write strobe
   input wire logic [AW-1:0] wr_addr, // Write address
   input wire logic [7:0] wr_data // Write data
);
   logic [7:0] mem [0:(1<<AW)-1];
   initial begin
      for (int i = 0; i < (1 << AW); i++) begin
         mem[i] = `DPEE_ERASED;
      end
   end
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
   end
endmodule

// >>> hw/dpee_pkg.sv
// Types shared by the dual-port EEPROM slave files
package dpee_pkg;
   typedef enum logic [2:0] {
      DPEE_IDLE,
      DPEE_DEVADR,
      DPEE_WORDADR,
      DPEE_WDATA,
      DPEE_RDATA,
      DPEE_WAITSTOP
   } dpee_state_t;
   typedef struct packed {
      logic clock;
      logic data;
   } dpee_bus_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } dpee_wr_t;
endpackage

// >>> hw/dpee_port.sv
// One serial slave port engine, running on the core clock with synchronised pins
`timescale 1ns/1ps
`include "dpee_defines.svh"
module dpee_port import dpee_pkg::*; (
   input wire logic core_clk, // Core clock
   input wire logic rst, // Synchronous reset
   input wire logic bus_clock, // Raw serial clock pin
   input wire logic bus_data_in, // Raw serial data pin level
   output logic bus_data_oe, // Pull data low
   input wire logic enabled, // Port may take commands
   input wire logic blocked, // Other party owns the write path
   input wire logic wr_protect_n, // Low blocks writes
   output logic want_write, // Write command LSB seen
   input wire logic granted, // This port owns the write path
   output logic [6:0] rd_addr, // Word address to read
   input wire logic [7:0] rd_data, // Data at rd_addr
   output logic commit_req, // Stop ended a granted write
   output logic [6:0] page_addr, // Page base for commit
   output logic [7:0] page_mask, // Bytes received
   output logic [63:0] page_data, // Page bytes
   output logic busy // Between start and stop
);
   // ---------------------------------------------------------------
   // Pin synchronisers: 3 flops, change counts when 2nd and 3rd agree
   // ---------------------------------------------------------------
   logic [2:0] scl_s, sda_s;
   logic scl, sda, scl_d, sda_d;
   always_ff @(posedge core_clk) begin
      scl_s <= {scl_s[1:0], bus_clock};
      sda_s <= {sda_s[1:0], bus_data_in};
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         scl <= 1'b1;
         sda <= 1'b1;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         if (scl_s[1] == scl_s[2]) scl <= scl_s[2];
         if (sda_s[1] == sda_s[2]) sda <= sda_s[2];
         scl_d <= scl;
         sda_d <= sda;
      end
   end
   wire scl_rise = scl & ~scl_d;
   wire scl_fall = ~scl & scl_d;
   wire start_det = scl & scl_d & sda_d & ~sda;
   wire stop_det = scl & scl_d & ~sda_d & sda;
   // ---------------------------------------------------------------
   // Byte engine
   // ---------------------------------------------------------------
   dpee_state_t state;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic [6:0] addr;
   logic ack_phase, rd_mode, got_data, wr_cmd;
   logic [7:0] tx;
   wire byte_done = scl_rise && bitcnt == 4'd7;
   wire [7:0] rx_byte = {shreg[6:0], sda};
   wire dev_match = rx_byte[7:1] == {`DPEE_DEV_TYPE, `DPEE_DEV_SEL};
   wire accept_dev = dev_match && enabled && !blocked;
   // Pointer moves before every byte but the first, so it rests on the last one written
   wire [2:0] wr_idx = got_data ? addr[2:0] + 3'd1 : addr[2:0];
   assign rd_addr = addr;
   assign busy = state != DPEE_IDLE;
   assign want_write = state == DPEE_DEVADR && bitcnt == 4'd7 && scl_rise && dev_match
                       && !sda && enabled && !blocked;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= DPEE_IDLE;
         bitcnt <= 4'd0;
         shreg <= 8'h00;
         addr <= 7'h00;
         ack_phase <= 1'b0;
         bus_data_oe <= 1'b0;
         rd_mode <= 1'b0;
         got_data <= 1'b0;
         wr_cmd <= 1'b0;
         tx <= 8'h00;
         commit_req <= 1'b0;
         page_addr <= 7'h00;
         page_mask <= 8'h00;
         page_data <= 64'h0;
      end else begin
         commit_req <= 1'b0;
         if (start_det) begin
            state <= DPEE_DEVADR;
            bitcnt <= 4'd0;
            ack_phase <= 1'b0;
            bus_data_oe <= 1'b0;
            wr_cmd <= 1'b0;
         end else if (stop_det) begin
            if (wr_cmd && got_data && granted && wr_protect_n) begin
               commit_req <= 1'b1;
            end
            state <= DPEE_IDLE;
            bus_data_oe <= 1'b0;
            got_data <= 1'b0;
            wr_cmd <= 1'b0;
            ack_phase <= 1'b0;
         end else if (state != DPEE_IDLE && state != DPEE_WAITSTOP) begin
            if (!ack_phase && scl_rise) begin
               shreg <= rx_byte;
               bitcnt <= bitcnt + 4'd1;
            end
            if (byte_done) begin
               ack_phase <= 1'b1;
               bitcnt <= 4'd0;
               unique case (state)
                  DPEE_DEVADR: begin
                     rd_mode <= rx_byte[0];
                     if (!accept_dev) state <= DPEE_WAITSTOP;
                     else if (!rx_byte[0]) wr_cmd <= 1'b1;
                  end
                  DPEE_WORDADR: begin
                     addr <= rx_byte[6:0];
                     page_addr <= {rx_byte[6:3], 3'b000};
                     page_mask <= 8'h00;
                     got_data <= 1'b0;
                  end
                  DPEE_WDATA: begin
                     addr <= {addr[6:3], wr_idx};
                     page_data[wr_idx*8 +: 8] <= rx_byte;
                     page_mask[wr_idx] <= 1'b1;
                     got_data <= 1'b1;
                  end
                  // Master answers a read byte on the ninth clock
                  DPEE_RDATA: ;
                  default: state <= DPEE_WAITSTOP;
               endcase
            end
            if (ack_phase && scl_rise) begin
               ack_phase <= 1'b0;
               unique case (state)
                  DPEE_DEVADR: state <= rd_mode ? DPEE_RDATA : DPEE_WORDADR;
                  DPEE_WORDADR: state <= DPEE_WDATA;
                  DPEE_RDATA: begin
                     addr <= addr + 7'd1;
                     if (sda) state <= DPEE_WAITSTOP;
                  end
                  default: ;
               endcase
            end
            if (scl_fall && ack_phase) begin
               bus_data_oe <= state != DPEE_RDATA;
            end else if (scl_fall && bitcnt == 4'd0) begin
               tx <= rd_data;
               bus_data_oe <= state == DPEE_RDATA && !rd_data[7];
            end else if (scl_fall && state == DPEE_RDATA) begin
               bus_data_oe <= ~tx[3'd7 - bitcnt[2:0]];
            end
         end
      end
   end
   AST_NO_ACK_IDLE: assert property (@(posedge core_clk) disable iff (rst)
      state == DPEE_IDLE && !start_det |=> !bus_data_oe)
      else $error("data driven while idle");
   AST_STOP_IDLE: assert property (@(posedge core_clk) disable iff (rst)
      stop_det |=> state == DPEE_IDLE && !bus_data_oe)
      else $error("stop not honoured");
   AST_COMMIT_STOP: assert property (@(posedge core_clk) disable iff (rst)
      commit_req |-> $past(stop_det) && $past(granted))
      else $error("commit without stop");
   AST_NO_WP_COMMIT: assert property (@(posedge core_clk) disable iff (rst)
      commit_req |-> $past(wr_protect_n))
      else $error("commit while protected");
   AST_PAGE_UPPER: assert property (@(posedge core_clk) disable iff (rst)
      state == DPEE_WDATA && $past(state) == DPEE_WDATA |-> addr[6:3] == $past(addr[6:3]))
      else $error("page upper bits moved");
   AST_BLOCKED_NOACK: assert property (@(posedge core_clk) disable iff (rst)
      state == DPEE_DEVADR && byte_done && blocked |=> state == DPEE_WAITSTOP)
      else $error("blocked port accepted");
   AST_NACK_STOPS: assert property (@(posedge core_clk) disable iff (rst)
      state == DPEE_RDATA && ack_phase && scl_rise && sda && !start_det && !stop_det
      |=> state == DPEE_WAITSTOP)
      else $error("nack ignored");
   AST_WAIT_QUIET: assert property (@(posedge core_clk) disable iff (rst)
      state == DPEE_WAITSTOP && $past(state) == DPEE_WAITSTOP |-> !bus_data_oe)
      else $error("talks while waiting for stop");
   COV_WRITE: cover property (@(posedge core_clk) commit_req);
   COV_READ: cover property (@(posedge core_clk) state == DPEE_RDATA && byte_done);
   COV_NACK: cover property (@(posedge core_clk) state == DPEE_WAITSTOP);
endmodule

// >>> hw/dpee_top.sv
// Dual-port serial EEPROM slave: two host ports, arbitration, commit, monitor
`timescale 1ns/1ps
`include "dpee_defines.svh"
module dpee_top import dpee_pkg::*; #(
   parameter int WRITE_CYCLES = `DPEE_WRITE_CYCLES
) (
   input wire logic core_clk, // Core clock, 250 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic host_a_clock, // Host port A clock pin
   input wire logic host_a_data_in, // Host port A data pin level
   output logic host_a_data_out, // Host port A data drive value (always 0)
   output logic host_a_data_oe, // Host port A pull low
   input wire logic host_b_clock, // Host port B clock pin
   input wire logic host_b_data_in, // Host port B data pin level
   output logic host_b_data_out, // Host port B data drive value (always 0)
   output logic host_b_data_oe, // Host port B pull low
   input wire logic port_mode_pin, // Low two-host, high one-host
   input wire logic bank_select_input, // Monitor port or bank select
   input wire logic write_protect_n, // Low blocks writes
   input wire logic monitor_enable_input, // Monitor pass-through enable
   output logic passthrough_clock_out, // Monitor clock value
   output logic passthrough_clock_oe, // Monitor clock drive enable
   output logic passthrough_data_out, // Monitor data value
   output logic passthrough_data_oe, // Monitor data drive enable
   output logic write_busy // Internal write cycle running
);
   // ---------------------------------------------------------------
   // Mode and bank decode
   // ---------------------------------------------------------------
   wire dual = !port_mode_pin;
   wire a_bank = dual ? 1'b0 : bank_select_input;
   wire b_en = dual;
   logic a_want, b_want, a_commit, b_commit, a_busy, b_busy;
   logic [6:0] a_rd, b_rd, a_pg, b_pg;
   logic [7:0] a_rdat, b_rdat, a_msk, b_msk;
   logic [63:0] a_pdat, b_pdat;
   logic owner_a, owner_b;
   logic [$clog2(WRITE_CYCLES+1)-1:0] wcnt;
   logic [2:0] widx;
   logic writing;
   logic commit_bank;
   logic [6:0] commit_pg;
   logic [7:0] commit_msk;
   logic [63:0] commit_dat;
   // ---------------------------------------------------------------
   // Write arbitration: first LSB wins; A wins a tie
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         owner_a <= 1'b0;
         owner_b <= 1'b0;
      end else if (writing && wcnt == '0 && widx == 3'd7) begin
         owner_a <= 1'b0;
         owner_b <= 1'b0;
      end else if (!writing && !owner_a && !owner_b) begin
         if (a_want) owner_a <= 1'b1;
         else if (b_want) owner_b <= 1'b1;
      end else if (!writing && owner_a && !a_busy && !a_commit) begin
         owner_a <= 1'b0;
      end else if (!writing && owner_b && !b_busy && !b_commit) begin
         owner_b <= 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // Internal write cycle: one byte per entry, then timed wait
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         writing <= 1'b0;
         wcnt <= '0;
         widx <= 3'd0;
         commit_bank <= 1'b0;
         commit_pg <= 7'h00;
         commit_msk <= 8'h00;
         commit_dat <= 64'h0;
      end else if (!writing && (a_commit || b_commit)) begin
         writing <= 1'b1;
         wcnt <= ($clog2(WRITE_CYCLES+1))'(WRITE_CYCLES);
         widx <= 3'd0;
         commit_bank <= a_commit ? a_bank : 1'b1;
         commit_pg <= a_commit ? a_pg : b_pg;
         commit_msk <= a_commit ? a_msk : b_msk;
         commit_dat <= a_commit ? a_pdat : b_pdat;
      end else if (writing) begin
         if (widx != 3'd7) widx <= widx + 3'd1;
         if (wcnt != '0) wcnt <= wcnt - 1'b1;
         else if (widx == 3'd7) writing <= 1'b0;
      end
   end
   assign write_busy = writing;
   wire mem_we = writing && wcnt == ($clog2(WRITE_CYCLES+1))'(WRITE_CYCLES) - widx
                 && commit_msk[widx];
   dpee_mem #(.AW(8)) u_mem (
      .core_clk(core_clk),
      .rd_a_addr({a_bank, a_rd}),
      .rd_a_data(a_rdat),
      .rd_b_addr({1'b1, b_rd}),
      .rd_b_data(b_rdat),
      .wr_en(mem_we),
      .wr_addr({commit_bank, commit_pg[6:3], widx}),
      .wr_data(commit_dat[widx*8 +: 8])
   );
   // ---------------------------------------------------------------
   // Port engines; both read in two-host mode, refused while the other owns the write path or a write cycle runs
   // ---------------------------------------------------------------
   dpee_port u_port_a (
      .core_clk(core_clk),
      .rst(rst),
      .bus_clock(host_a_clock),
      .bus_data_in(host_a_data_in),
      .bus_data_oe(host_a_data_oe),
      .enabled(1'b1),
      .blocked(writing || owner_b),
      .wr_protect_n(write_protect_n),
      .want_write(a_want),
      .granted(owner_a),
      .rd_addr(a_rd),
      .rd_data(a_rdat),
      .commit_req(a_commit),
      .page_addr(a_pg),
      .page_mask(a_msk),
      .page_data(a_pdat),
      .busy(a_busy)
   );
   dpee_port u_port_b (
      .core_clk(core_clk),
      .rst(rst),
      .bus_clock(host_b_clock),
      .bus_data_in(host_b_data_in),
      .bus_data_oe(host_b_data_oe),
      .enabled(b_en),
      .blocked(writing || owner_a),
      .wr_protect_n(write_protect_n),
      .want_write(b_want),
      .granted(owner_b),
      .rd_addr(b_rd),
      .rd_data(b_rdat),
      .commit_req(b_commit),
      .page_addr(b_pg),
      .page_mask(b_msk),
      .page_data(b_pdat),
      .busy(b_busy)
   );
   assign host_a_data_out = 1'b0;
   assign host_b_data_out = 1'b0;
   // ---------------------------------------------------------------
   // Monitor pass-through: a switch, so combinational on raw pins
   // ---------------------------------------------------------------
   wire mon_b = dual && bank_select_input;
   assign passthrough_clock_out = mon_b ? host_b_clock : host_a_clock;
   assign passthrough_data_out = mon_b ? host_b_data_in : host_a_data_in;
   assign passthrough_clock_oe = monitor_enable_input;
   assign passthrough_data_oe = monitor_enable_input;
   AST_ONE_OWNER: assert property (@(posedge core_clk) disable iff (rst)
      !(owner_a && owner_b))
      else $error("two write owners");
   AST_B_IDLE_SINGLE: assert property (@(posedge core_clk) disable iff (rst)
      port_mode_pin && $past(port_mode_pin) |-> !owner_b || $past(owner_b))
      else $error("port B won write in one-host mode");
   AST_MON_ENABLE: assert property (@(posedge core_clk) disable iff (rst)
      passthrough_data_oe == monitor_enable_input)
      else $error("monitor enable wrong");
   COV_BOTH_BUSY: cover property (@(posedge core_clk) a_busy && b_busy);
   COV_WRITE_END: cover property (@(posedge core_clk) $fell(writing));
endmodule

// >>> verification/dpee_host_model.sv
// Serial host master model for one port of the EEPROM front end
`timescale 1ns/1ps
module dpee_host_model (
   output logic clk_pin, // Serial clock, still between frames
   output logic pull_low, // Master pulls data low
   input wire logic data_in // Resolved data level
);
   // Quarter of the 80 ns link period
   localparam int Q = 20;
   initial begin
      clk_pin = 1'b1;
      pull_low = 1'b0;
   end
   task automatic start();
      // Give the slave time to drop its acknowledge before a repeated start
      #(Q);
      pull_low = 1'b0;
      #(Q);
      clk_pin = 1'b1;
      #(2*Q);
      pull_low = 1'b1;
      #(2*Q);
      clk_pin = 1'b0;
   endtask
   task automatic stop();
      #(Q);
      pull_low = 1'b1;
      #(Q);
      clk_pin = 1'b1;
      #(2*Q);
      pull_low = 1'b0;
      #(4*Q);
   endtask
   // Released data reads high through the pull-up, never a stale level
   task automatic bit_io(input logic b, output logic r);
      #(Q);
      pull_low = !b;
      #(Q);
      clk_pin = 1'b1;
      #(Q);
      r = data_in;
      #(Q);
      clk_pin = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic r9, output logic [7:0] rx,
                       output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(r9, s);
      ack = !s;
   endtask
endmodule

// >>> verification/dual_port_serial_eeprom_slave_bench.sv
// Self-checking bench for the dual-port serial EEPROM slave
`timescale 1ns/1ps
module dual_port_serial_eeprom_slave_bench;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic a_clk, b_clk, a_pull, b_pull, a_oe, b_oe, mon_clk, mon_oe, mon_dat, mon_doe, wb;
   logic mode = 1'b0;
   logic bsel = 1'b0;
   logic wp_n = 1'b1;
   logic mon_en = 1'b1;
   int err_total = 0;
   int n_tests = 0;
   wire logic a_din = !(a_oe | a_pull);
   wire logic b_din = !(b_oe | b_pull);
   always #2 core_clk = ~core_clk;
   dpee_top #(.WRITE_CYCLES(600)) u_dpee_top (
      .core_clk(core_clk), .rst(rst),
      .host_a_clock(a_clk), .host_a_data_in(a_din), .host_a_data_out(), .host_a_data_oe(a_oe),
      .host_b_clock(b_clk), .host_b_data_in(b_din), .host_b_data_out(), .host_b_data_oe(b_oe),
      .port_mode_pin(mode), .bank_select_input(bsel), .write_protect_n(wp_n),
      .monitor_enable_input(mon_en), .passthrough_clock_out(mon_clk),
      .passthrough_clock_oe(mon_oe), .passthrough_data_out(mon_dat), .passthrough_data_oe(mon_doe),
      .write_busy(wb)
   );
   dpee_host_model u_host_a (.clk_pin(a_clk), .pull_low(a_pull), .data_in(a_din));
   dpee_host_model u_host_b (.clk_pin(b_clk), .pull_low(b_pull), .data_in(b_din));
   task automatic finish_test();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic pins(input logic m, input logic bs, input logic me, input logic wp);
      @(posedge core_clk);
      #1;
      mode = m;
      bsel = bs;
      mon_en = me;
      wp_n = wp;
   endtask
   task automatic st(input bit p);
      if (p) u_host_b.start();
      else u_host_a.start();
   endtask
   task automatic sp(input bit p);
      if (p) u_host_b.stop();
      else u_host_a.stop();
   endtask
   task automatic xf(input bit p, input logic [7:0] tx, input logic r9, output logic [7:0] rx,
                     output logic k);
      if (p) u_host_b.xfer(tx, r9, rx, k);
      else u_host_a.xfer(tx, r9, rx, k);
   endtask
   // Address byte alone, then stop; expected acknowledge given
   task automatic adr(input bit p, input logic [7:0] a, input logic e);
      logic [7:0] rx;
      logic k;
      st(p);
      xf(p, a, 1'b1, rx, k);
      chk("adr_ack", {7'h0, e}, {7'h0, k});
      sp(p);
   endtask
   task automatic wr(input bit p, input logic [7:0] a, input logic [7:0] d[$], input bit ck);
      logic [7:0] rx;
      logic k;
      st(p);
      xf(p, 8'hA0, 1'b1, rx, k);
      chk("wr_adr_ack", 8'h01, {7'h0, k});
      xf(p, a, 1'b1, rx, k);
      foreach (d[i]) begin
         xf(p, d[i], 1'b1, rx, k);
         if (ck) chk("wr_dat_ack", 8'h01, {7'h0, k});
      end
      sp(p);
   endtask
   task automatic rd(input bit p, input logic [7:0] a, input logic [7:0] e[$]);
      logic [7:0] rx;
      logic k;
      st(p);
      xf(p, 8'hA0, 1'b1, rx, k);
      xf(p, a, 1'b1, rx, k);
      st(p);
      xf(p, 8'hA1, 1'b1, rx, k);
      foreach (e[i]) begin
         xf(p, 8'hFF, i == e.size() - 1, rx, k);
         chk("rd_data", e[i], rx);
      end
      sp(p);
   endtask
   task automatic cur(input bit p, input logic [7:0] e);
      logic [7:0] rx;
      logic k;
      st(p);
      xf(p, 8'hA1, 1'b1, rx, k);
      xf(p, 8'hFF, 1'b1, rx, k);
      chk("cur_data", e, rx);
      #30;
      chk("released", 8'h00, {7'h0, p ? b_oe : a_oe});
      sp(p);
   endtask
   // Bounded acknowledge polling; exhaustion ends the run
   task automatic poll(input bit p);
      logic [7:0] rx;
      logic k;
      k = 1'b0;
      for (int i = 0; i < 40 && k !== 1'b1; i++) begin
         st(p);
         xf(p, 8'hA0, 1'b1, rx, k);
         sp(p);
      end
      if (k !== 1'b1) begin
         err_total++;
         $display("ERROR poll_ack expected 1 seen 0");
         finish_test();
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] rx;
      logic k;
      repeat (4) @(posedge core_clk);
      #1;
      rst = 1'b0;
      repeat (8) @(posedge core_clk);
      wr(0, 8'h05, '{8'h3C}, 1);
      chk("write_busy", 8'h01, {7'h0, wb});
      adr(0, 8'hA0, 1'b0);
      poll(0);
      cur(0, 8'h3C);
      wr(0, 8'h10, '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19}, 1);
      poll(0);
      rd(0, 8'h10, '{8'h19, 8'h12, 8'h13});
      cur(0, 8'h14);
      adr(0, 8'hA2, 1'b0);
      st(0);
      xf(0, 8'hA0, 1'b1, rx, k);
      xf(0, 8'h30, 1'b1, rx, k);
      adr(1, 8'hA1, 1'b0);
      xf(0, 8'h77, 1'b1, rx, k);
      sp(0);
      poll(0);
      rd(0, 8'h30, '{8'h77});
      pins(0, 1, 1, 1);
      chk("mon_doe", 8'h01, {7'h0, mon_doe});
      rd(1, 8'h10, '{8'hFF});
      rd(0, 8'h10, '{8'h19});
      // Current reads only: a write command would claim the write path
      fork
         cur(0, 8'h12);
         begin
            #200;
            cur(1, 8'hFF);
         end
         repeat (60) begin
            #37;
            chk("mon_clk", {7'h0, b_clk}, {7'h0, mon_clk});
            chk("mon_dat", {7'h0, b_din}, {7'h0, mon_dat});
         end
      join
      pins(0, 1, 0, 1);
      chk("mon_oe", 8'h00, {7'h0, mon_oe});
      chk("mon_doe", 8'h00, {7'h0, mon_doe});
      pins(0, 0, 1, 0);
      wr(0, 8'h40, '{8'h55}, 0);
      poll(0);
      rd(0, 8'h40, '{8'hFF});
      pins(1, 1, 1, 1);
      rd(0, 8'h10, '{8'hFF});
      adr(1, 8'hA1, 1'b0);
      pins(1, 0, 1, 1);
      rd(0, 8'h10, '{8'h19});
      finish_test();
   end
endmodule
